/* core/adc_host_defines.vh */
// Timing and layout constants for the converter host controller
`ifndef ADC_HOST_DEFINES_VH
`define ADC_HOST_DEFINES_VH
`define CLK_PERIOD_NS 25
`define READ_WAIT_NS 6500
`define READ_WAIT_CYC ((`READ_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_PERIOD_NS 6000
`define CONV_PERIOD_CYC ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_LOW_CYC 2
`define STROBE_CYC 4
`define BYTE_ADDR_LO 1'b0
`define BYTE_ADDR_HI 1'b1
`define AVG_SHIFT 1
`endif

/* core/adc_word_buffer.v */
// Two-entry skid buffer for conversion results
`default_nettype none
module adc_word_buffer #(
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire reset_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] spare;
    reg [1:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count <= 2'h0;
            spare <= {WIDTH{1'b0}};
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) out_data_o <= in_data_i;
                    else spare <= in_data_i;
                    count <= count + 2'h1;
                end
                2'b01: begin
                    out_data_o <= spare;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    if (count == 2'h1) out_data_o <= in_data_i;
                    else begin
                        out_data_o <= spare;
                        spare <= in_data_i;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* core/adc_conversion_host.v */
// Host-side controller that triggers conversions and reads results
// What this block does
// - Start each conversion with trigger low
// - Read only after completion or 6.5us
// - Standalone: timer triggers, latch on busy
// - Keep data bus quiet during conversion
// - Optional averaging of two samples
`default_nettype none
`include "adc_host_defines.vh"
module adc_conversion_host #(
    parameter BYTE_MODE = 0,
    parameter AVERAGE = 0,
    parameter WAIT_FOR_BUSY = 1,
    parameter PERIOD_CYC = `CONV_PERIOD_CYC
) (
    input wire REF_CLK_I,
    input wire RESET_I,
    input wire ENABLE_I,
    input wire START_I,
    output reg SAMPLE_TRIGGER_N_O,
    input wire BUSY_N_I,
    output reg HOST_DECODE_SELECT_N_O,
    output reg READ_N_O,
    output reg BYTE_ADDR_O,
    input wire [15:0] DATA_I,
    output wire RESULT_VALID_O,
    input wire RESULT_READY_I,
    output wire [15:0] RESULT_O,
    output reg OVERRUN_O
);
    // ----------------------------------------------------------------
    // States and helpers
    // ----------------------------------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_TRIG = 3'h1;
    localparam S_CONV = 3'h2;
    localparam S_RD_LO = 3'h3;
    localparam S_RD_HI = 3'h4;
    localparam S_PUSH = 3'h5;
    localparam S_GAP = 3'h6;
    localparam S_RD_SEP = 3'h7;

    // Counts held at the counter's width so every compare is 16 bits on both sides
    localparam integer TRIG_LAST_I = `TRIG_LOW_CYC - 1;
    localparam integer STROBE_LAST_I = `STROBE_CYC;
    localparam integer READ_WAIT_I = `READ_WAIT_CYC;
    localparam [15:0] TRIG_LAST = TRIG_LAST_I[15:0];
    localparam [15:0] STROBE_LAST = STROBE_LAST_I[15:0];
    localparam [15:0] READ_WAIT = READ_WAIT_I[15:0];

    function [15:0] avg2;
        input [15:0] a;
        input [15:0] b;
        reg [16:0] s;
        begin
            s = {a[15], a} + {b[15], b};
            avg2 = s[16:`AVG_SHIFT];
        end
    endfunction

    reg [2:0] state;
    reg [15:0] cnt;
    reg [15:0] period;
    reg [15:0] word;
    reg [15:0] prev;
    reg have_prev;
    reg busy_s1;
    reg busy_s2;
    reg busy_d;
    reg [15:0] data_s1;
    reg [15:0] data_s2;
    reg run;
    wire buf_ready;
    wire busy_rise = busy_s2 && !busy_d;
    wire strobe_done = (cnt == STROBE_LAST);
    wire period_done = (period >= PERIOD_CYC[15:0]);
    wire [15:0] push_word = (AVERAGE != 0) ? avg2(prev, word) : word;
    wire push = (state == S_PUSH) && ((AVERAGE == 0) || have_prev);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
            busy_d <= 1'b1;
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
        end else begin
            busy_s1 <= BUSY_N_I;
            busy_s2 <= busy_s1;
            busy_d <= busy_s2;
            data_s1 <= DATA_I;
            data_s2 <= data_s1;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state <= S_IDLE;
            cnt <= 16'h0000;
            period <= 16'h0000;
            word <= 16'h0000;
            prev <= 16'h0000;
            have_prev <= 1'b0;
            run <= 1'b0;
            SAMPLE_TRIGGER_N_O <= 1'b1;
            HOST_DECODE_SELECT_N_O <= 1'b1;
            READ_N_O <= 1'b1;
            BYTE_ADDR_O <= `BYTE_ADDR_LO;
            OVERRUN_O <= 1'b0;
        end else begin
            OVERRUN_O <= 1'b0;
            if (period != 16'hffff) period <= period + 16'h0001;
            case (state)
                S_IDLE: begin
                    // Free run paced by the period counter; single shot by START_I
                    if ((ENABLE_I && period_done) || START_I) begin
                        state <= S_TRIG;
                        SAMPLE_TRIGGER_N_O <= 1'b0;
                        cnt <= 16'h0000;
                        period <= 16'h0000;
                    end
                end
                S_TRIG: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == TRIG_LAST) begin
                        SAMPLE_TRIGGER_N_O <= 1'b1;
                        cnt <= 16'h0000;
                        run <= 1'b0;
                        state <= S_CONV;
                    end
                end
                S_CONV: begin
                    // Bus stays released until busy returns high, or until READ_WAIT cycles pass when WAIT_FOR_BUSY is 0
                    cnt <= cnt + 16'h0001;
                    if (!busy_s2) run <= 1'b1;
                    if ((WAIT_FOR_BUSY != 0) ? (run && busy_rise)
                        : (cnt >= READ_WAIT)) begin
                        cnt <= 16'h0000;
                        HOST_DECODE_SELECT_N_O <= 1'b0;
                        READ_N_O <= 1'b0;
                        BYTE_ADDR_O <= (BYTE_MODE != 0) ? `BYTE_ADDR_HI : `BYTE_ADDR_LO;
                        state <= S_RD_HI;
                    end
                end
                S_RD_HI: begin
                    cnt <= cnt + 16'h0001;
                    if (strobe_done) begin
                        cnt <= 16'h0000;
                        if (BYTE_MODE != 0) begin
                            // Two separate accesses; the address only moves on an edge where the select also changes
                            word[15:8] <= data_s2[7:0];
                            HOST_DECODE_SELECT_N_O <= 1'b1;
                            READ_N_O <= 1'b1;
                            BYTE_ADDR_O <= `BYTE_ADDR_LO;
                            state <= S_RD_SEP;
                        end else begin
                            word <= data_s2;
                            HOST_DECODE_SELECT_N_O <= 1'b1;
                            READ_N_O <= 1'b1;
                            state <= S_PUSH;
                        end
                    end
                end
                S_RD_SEP: begin
                    HOST_DECODE_SELECT_N_O <= 1'b0;
                    READ_N_O <= 1'b0;
                    state <= S_RD_LO;
                end
                S_RD_LO: begin
                    cnt <= cnt + 16'h0001;
                    if (strobe_done) begin
                        word[7:0] <= data_s2[7:0];
                        HOST_DECODE_SELECT_N_O <= 1'b1;
                        READ_N_O <= 1'b1;
                        state <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    // Sign-extended sum keeps two's complement averaging exact
                    if (AVERAGE != 0) begin
                        prev <= word;
                        have_prev <= !have_prev;
                    end
                    if (push && !buf_ready) OVERRUN_O <= 1'b1;
                    state <= S_GAP;
                end
                S_GAP: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Result buffer
    // ----------------------------------------------------------------
    adc_word_buffer #(
        .WIDTH(16)
    ) u_buf (
        .clk_i(REF_CLK_I),
        .reset_i(RESET_I),
        .in_valid_i(push),
        .in_ready_o(buf_ready),
        .in_data_i(push_word),
        .out_valid_o(RESULT_VALID_O),
        .out_ready_i(RESULT_READY_I),
        .out_data_o(RESULT_O)
    );
endmodule
`default_nettype wire

/* tb/adc_device_model.sv */
// Behavioural model of the converter seen from the host side
`default_nettype none
module adc_device_model #(
    // Off the 25 ns grid so busy never rises on a sampling edge
    parameter int CONV_NS = 5010,
    parameter int PHASE1_NS = 3350,
    parameter bit BYTE_BUS = 1'b0
) (
    input wire logic trig_n_i,
    input wire logic sel_n_i,
    input wire logic rd_n_i,
    input wire logic addr_i,
    output logic busy_n_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] res = 16'h0000;
    logic [15:0] bus_word;
    int k = 0;
    initial busy_n_o = 1'b1;
    // ----------------------------------------
    // Conversion: hold, two phases, done
    // ----------------------------------------
    always begin
        // A full low-high pulse is needed; the X to 1 at power-up starts nothing
        @(negedge trig_n_i);
        @(posedge trig_n_i);
        #50 busy_n_o = 1'b0;
        #(PHASE1_NS);
        #(CONV_NS - PHASE1_NS) res = 16'h8000 + 16'h0f1d * k[15:0];
        k++;
        busy_n_o = 1'b1;
    end
    // Idle bus shows inverted data so a stale sample cannot pass
    always @* begin
        if (BYTE_BUS == 1'b0) begin
            bus_word = res;
        end else if (addr_i) begin
            bus_word = {8'h00, res[15:8]};
        end else begin
            bus_word = {8'h00, res[7:0]};
        end
        if (!sel_n_i && !rd_n_i) begin
            data_o = bus_word;
        end else begin
            data_o = ~bus_word;
        end
    end
endmodule
`default_nettype wire

/* tb/adc_host_checker.sv */
// Assertions on the converter host controller ports
`default_nettype none
module adc_host_checker (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic SAMPLE_TRIGGER_N_O,
    input wire logic BUSY_N_I,
    input wire logic HOST_DECODE_SELECT_N_O,
    input wire logic READ_N_O,
    input wire logic BYTE_ADDR_O,
    input wire logic RESULT_VALID_O,
    input wire logic RESULT_READY_I,
    input wire logic [15:0] RESULT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    AST_TRIG_WIDTH: assert property
        ($fell(SAMPLE_TRIGGER_N_O) |=> !SAMPLE_TRIGGER_N_O ##1 SAMPLE_TRIGGER_N_O)
        else $error("trigger pulse width wrong");
    AST_NO_TRIG_BUSY: assert property (!BUSY_N_I |-> SAMPLE_TRIGGER_N_O)
        else $error("trigger while busy");
    AST_READ_AFTER_DONE: assert property ($fell(READ_N_O) |-> $past(BUSY_N_I, 3))
        else $error("read before completion");
    AST_SEL_WITH_READ: assert property (READ_N_O == HOST_DECODE_SELECT_N_O)
        else $error("select and read differ");
    AST_QUIET_BUS: assert property (!BUSY_N_I |-> READ_N_O)
        else $error("bus read during conversion");
    AST_READ_LEN: assert property
        ($fell(READ_N_O) |-> (!READ_N_O)[*5] ##1 READ_N_O)
        else $error("read strobe length wrong");
    AST_GAP: assert property
        ($fell(SAMPLE_TRIGGER_N_O) |-> $past(READ_N_O, 2) && $past(READ_N_O))
        else $error("trigger too close to read");
    AST_HOLD_RESULT: assert property
        (RESULT_VALID_O && !RESULT_READY_I |=> RESULT_VALID_O && $stable(RESULT_O))
        else $error("result changed while stalled");
    AST_ADDR_STABLE: assert property
        (!READ_N_O && !$past(READ_N_O) |-> $stable(BYTE_ADDR_O))
        else $error("byte address moved during a read");
endmodule
bind adc_conversion_host adc_host_checker chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
    .SAMPLE_TRIGGER_N_O(SAMPLE_TRIGGER_N_O), .BUSY_N_I(BUSY_N_I),
    .HOST_DECODE_SELECT_N_O(HOST_DECODE_SELECT_N_O), .READ_N_O(READ_N_O),
    .BYTE_ADDR_O(BYTE_ADDR_O),
    .RESULT_VALID_O(RESULT_VALID_O), .RESULT_READY_I(RESULT_READY_I), .RESULT_O(RESULT_O));
`default_nettype wire

/* tb/adc_conversion_host_tb.sv */
// Self-checking bench for the converter host controller
`default_nettype none
module adc_conversion_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, start = 1'b0, rdy = 1'b0;
    logic en_b = 1'b0, rdy_b = 1'b0;
    wire trig_b, busy_b, sel_b, rd_b, addr_b, valid_b;
    wire [15:0] dbus_b, res_b;
    wire trig_n, busy_n, sel_n, rd_n, baddr, valid, ovr;
    wire [15:0] dbus, res;
    int n_fail = 0, samples_checked = 0, cyc = 0, k = 0;
    always #12.5 clk = ~clk;
    adc_conversion_host uut (.REF_CLK_I(clk), .RESET_I(rst),
        .ENABLE_I(en), .START_I(start), .SAMPLE_TRIGGER_N_O(trig_n), .BUSY_N_I(busy_n),
        .HOST_DECODE_SELECT_N_O(sel_n), .READ_N_O(rd_n), .BYTE_ADDR_O(baddr),
        .DATA_I(dbus), .RESULT_VALID_O(valid), .RESULT_READY_I(rdy), .RESULT_O(res),
        .OVERRUN_O(ovr));
    adc_device_model dev (.trig_n_i(trig_n), .sel_n_i(sel_n), .rd_n_i(rd_n),
        .addr_i(baddr), .busy_n_o(busy_n), .data_o(dbus));
    // Byte bus, fixed wait instead of busy, two-sample averaging
    adc_conversion_host #(.BYTE_MODE(1), .AVERAGE(1), .WAIT_FOR_BUSY(0)) uut_byte (
        .REF_CLK_I(clk), .RESET_I(rst), .ENABLE_I(en_b), .START_I(1'b0),
        .SAMPLE_TRIGGER_N_O(trig_b), .BUSY_N_I(busy_b), .HOST_DECODE_SELECT_N_O(sel_b),
        .READ_N_O(rd_b), .BYTE_ADDR_O(addr_b), .DATA_I(dbus_b), .RESULT_VALID_O(valid_b),
        .RESULT_READY_I(rdy_b), .RESULT_O(res_b), .OVERRUN_O());
    adc_device_model #(.BYTE_BUS(1'b1)) dev_b (.trig_n_i(trig_b), .sel_n_i(sel_b),
        .rd_n_i(rd_b), .addr_i(addr_b), .busy_n_o(busy_b), .data_o(dbus_b));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Falling edge only: the X to 1 at power-up must not count as a conversion
    always @(negedge trig_n) k++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop;
        end
    end
    function automatic logic [15:0] expv(int i);
        return 16'h8000 + 16'h0f1d * i[15:0];
    endfunction
    // Signed mean of samples i and i+1, rounded toward minus infinity
    function automatic logic [15:0] avgv(int i);
        int s;
        s = $signed(expv(i)) + $signed(expv(i + 1));
        return 16'(s >>> 1);
    endfunction
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    // Waits a bounded time, then takes one word
    task take(input logic [15:0] e);
        for (int i = 0; i < 600 && valid !== 1'b1; i++) @(negedge clk);
        chk("valid", 16'h0001, {15'h0, valid});
        chk("result", e, res);
        rdy = 1'b1;
        @(negedge clk);
        rdy = 1'b0;
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_single;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        take(expv(0));
        repeat (300) @(negedge clk);
        chk("idle valid", 16'h0000, {15'h0, valid});
    endtask
    // Receiver stalls: two words kept, the third dropped
    task t_stall;
        int base;
        logic seen;
        base = k;
        seen = 1'b0;
        en = 1'b1;
        for (int i = 0; i < 1500 && !seen; i++) begin
            @(negedge clk);
            seen = (ovr === 1'b1);
        end
        en = 1'b0;
        chk("overrun", 16'h0001, {15'h0, seen});
        repeat (400) @(negedge clk);
        take(expv(base));
        take(expv(base + 1));
        chk("drained valid", 16'h0000, {15'h0, valid});
    endtask
    task t_stream;
        int base;
        base = k;
        en = 1'b1;
        for (int i = 0; i < 4; i++) take(expv(base + i));
        en = 1'b0;
    endtask
    // Byte reads after the fixed wait, two samples averaged into one word
    task t_byte_avg;
        en_b = 1'b1;
        for (int i = 0; i < 1200 && valid_b !== 1'b1; i++) @(negedge clk);
        en_b = 1'b0;
        chk("byte valid", 16'h0001, {15'h0, valid_b});
        chk("byte mean", avgv(0), res_b);
        rdy_b = 1'b1;
        @(negedge clk);
        rdy_b = 1'b0;
        repeat (3) @(negedge clk);
        chk("byte drained", 16'h0000, {15'h0, valid_b});
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_single;
        t_stall;
        t_stream;
        t_byte_avg;
        report_and_stop;
    end
endmodule
`default_nettype wire
